// ### hdl/i2cm_pkg.sv
// shared constants of the ten-bit-address i2c master
package i2cm_pkg;
  // ==========================================================
  // link operations passed from the core side to the bit engine
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_STOP = 3'h4;
  // ==========================================================
  // address and framing
  localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] ADDR_ONE = 2'h1;
  localparam logic [1:0] ADDR_TWO = 2'h2;
  // ==========================================================
  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] BIT_RST = 4'h0;
  localparam logic [1:0] ADDR_RST = 2'h0;
endpackage : i2cm_pkg

// ### hdl/i2cm_sync.sv
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns
module i2cm_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // no reset: the reset itself may pass through here
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end

  assign q = q_reg;
endmodule : i2cm_sync

// ### hdl/i2cm_tgl_rx.sv
// receives a toggle from another domain and gives a one-cycle pulse
`timescale 1ns/1ns
module i2cm_tgl_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // event
  input wire logic tgl,
  output logic pulse
);
  // ==========================================================
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= tgl;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign pulse = sync_reg ^ prev_reg;
endmodule : i2cm_tgl_rx

// ### hdl/i2cm_top.sv
// ten-bit-address i2c master: software side on CORE_CLK, bit engine on LINK_CLK
`timescale 1ns/1ns
// Summary of operation
// R1 - load the data register into the shift register before each transmitted byte
// R2 - raise transmit interrupt once the first bit of a loaded byte is out
// R3 - ten-bit write header is 11110, two upper address bits, then write bit 0
// R4 - slave acknowledges each sent byte by holding SDA low while SCL high
// R5 - on transmit interrupt software writes the low eight address bits
// R6 - start bit set mid-transfer gives a repeated START instead of STOP
// R7 - after second address byte is acknowledged, send the repeated START
// R8 - after repeated START send the header, upper address bits and read bit 1
// R9 - with NAK bit set, answer the next received byte with Not Acknowledge
// R10 - raise receive interrupt once a full data byte is received
// R11 - receive flag stays set until software reads data, which clears it
// R12 - software sets stop bit after reading the final byte
// R13 - with NAK pending and stop set, send NAK first, then STOP; in C_HOLD the core sends STOP first and drops a NAK read not yet begun
// R14 - acknowledge flag reports acknowledge of the last byte sent or received
// R15 - ten-bit flag set at start on header match, cleared after first address byte
// R16 - direction flag takes shift register bit 0 at start, high for read
// R17 - address-shift flag high exactly while address bits shift out
// R18 - data-shift flag high exactly while data bits shift in or out
// R19 - not-ack flag sets on NAK sent or received with start and stop idle
// R20 - not-ack flag interrupts and clears only when start or stop is set
// R21 - master drives SCL per bit and samples SDA while SCL is high
module i2cm_top (
  // clocks and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic LINK_CLK,
  // software data access
  input wire logic [7:0] DATA_IN,
  input wire logic DATA_WR,
  input wire logic DATA_RD,
  output logic [7:0] DATA_OUT,
  // control bits
  input wire logic START_SET,
  input wire logic STOP_SET,
  input wire logic NAK_SET,
  output logic START_BIT,
  output logic STOP_BIT,
  output logic NAK_BIT,
  // status and interrupts
  output logic TX_IRQ,
  output logic RX_IRQ,
  output logic ACK_FLAG,
  output logic TEN_BIT_ADDR_FLAG,
  output logic READ_DIR,
  output logic ADDR_SHIFT_STATE,
  output logic DATA_SHIFT_STATE,
  output logic NOT_ACK_IRQ_FLAG,
  // bus pins
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE
);
  // ==========================================================
  // core side state
  typedef enum logic [2:0] {C_IDLE, C_STARTW, C_ADDRW, C_LOADA, C_HOLD, C_DATAW, C_READW, C_STOPW} i2cm_core_e;
  i2cm_core_e c_state_reg, c_state_next;
  logic [7:0] data_reg, data_next, shift_reg, shift_next, rx_data_reg, rx_data_next;
  logic data_full_reg, data_full_next, start_reg, start_next, stop_reg, stop_next, nak_reg, nak_next;
  logic nak_done_reg, nak_done_next, tx_irq_reg, tx_irq_next, rx_irq_reg, rx_irq_next;
  logic ack_reg, ack_next, ten_reg, ten_next, rd_reg, rd_next, nack_irq_reg, nack_irq_next;
  logic addr_st_reg, addr_st_next, data_st_reg, data_st_next, cmd_tgl_reg, cmd_tgl_next;
  logic [2:0] cmd_op_reg, cmd_op_next;
  logic cmd_nak_reg, cmd_nak_next;
  logic [1:0] addr_left_reg, addr_left_next;
  logic done_evt, first_evt;
  // link side state
  typedef enum logic [1:0] {L_IDLE, L_START, L_BIT, L_STOP} i2cm_link_e;
  i2cm_link_e l_state_reg, l_state_next;
  logic [1:0] l_ph_reg, l_ph_next;
  logic [3:0] l_bit_reg, l_bit_next;
  logic [2:0] l_op_reg, l_op_next;
  logic [7:0] l_sh_reg, l_sh_next, l_rx_reg, l_rx_next;
  logic l_nak_reg, l_nak_next, l_ack_reg, l_ack_next, done_tgl_reg, done_tgl_next;
  logic first_tgl_reg, first_tgl_next, scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic pin_low_reg;
  logic [2:0] l_in;
  logic l_rst_b, cmd_evt, scl_s, sda_s;

  // ==========================================================
  // crossings: words stay stable while their toggle is in flight
  i2cm_sync #(.W(3)) u_lsync (.clk(LINK_CLK), .d({RST_B, SCL_IN, SDA_IN}), .q(l_in));
  assign l_rst_b = l_in[2];
  assign scl_s = l_in[1];
  assign sda_s = l_in[0];
  i2cm_tgl_rx u_cmd (.clk(LINK_CLK), .rst_b(l_rst_b), .tgl(cmd_tgl_reg), .pulse(cmd_evt));
  i2cm_tgl_rx u_done (.clk(CORE_CLK), .rst_b(RST_B), .tgl(done_tgl_reg), .pulse(done_evt));
  i2cm_tgl_rx u_first (.clk(CORE_CLK), .rst_b(RST_B), .tgl(first_tgl_reg), .pulse(first_evt));

  // ==========================================================
  // core sequencer
  always_comb begin
    c_state_next = c_state_reg;
    data_next = data_reg;
    data_full_next = data_full_reg;
    shift_next = shift_reg;
    rx_data_next = rx_data_reg;
    start_next = start_reg;
    stop_next = stop_reg;
    nak_next = nak_reg;
    nak_done_next = nak_done_reg;
    tx_irq_next = tx_irq_reg;
    rx_irq_next = rx_irq_reg;
    ack_next = ack_reg;
    ten_next = ten_reg;
    rd_next = rd_reg;
    nack_irq_next = nack_irq_reg;
    cmd_tgl_next = cmd_tgl_reg;
    cmd_op_next = cmd_op_reg;
    cmd_nak_next = cmd_nak_reg;
    addr_left_next = addr_left_reg;
    if (DATA_WR) begin
      data_next = DATA_IN;
      data_full_next = 1'b1;
      tx_irq_next = 1'b0;
    end
    if (DATA_RD) begin
      rx_irq_next = 1'b0; // [R11]
    end
    if (START_SET || STOP_SET) begin
      nack_irq_next = 1'b0; // [R20]
    end
    unique case (c_state_reg)
      C_IDLE: begin
        if (start_reg && data_full_reg) begin
          cmd_op_next = i2cm_pkg::OP_START;
          cmd_tgl_next = ~cmd_tgl_reg;
          start_next = 1'b0;
          c_state_next = C_STARTW;
        end
      end
      C_STARTW: begin
        if (done_evt) begin
          shift_next = data_reg; // [R1] [R3] [R8]
          data_full_next = DATA_WR;
          ten_next = (data_reg[7:3] == i2cm_pkg::TEN_BIT_HDR); // [R15]
          rd_next = data_reg[0]; // [R16]
          addr_left_next = (data_reg[7:3] == i2cm_pkg::TEN_BIT_HDR) && !data_reg[0] ?
                           i2cm_pkg::ADDR_TWO : i2cm_pkg::ADDR_ONE;
          cmd_op_next = i2cm_pkg::OP_WRITE;
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_ADDRW;
        end
      end
      C_ADDRW: begin
        if (done_evt) begin
          ack_next = l_ack_reg; // [R14] [R4]
          ten_next = 1'b0; // [R15]
          addr_left_next = addr_left_reg - i2cm_pkg::ADDR_ONE;
          // second ten-bit byte comes from software after the transmit interrupt
          c_state_next = (l_ack_reg && addr_left_reg == i2cm_pkg::ADDR_TWO) ? C_LOADA : C_HOLD; // [R5]
        end
      end
      C_LOADA: begin
        if (stop_reg) begin
          cmd_op_next = i2cm_pkg::OP_STOP;
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_STOPW;
        end else if (data_full_reg) begin
          shift_next = data_reg; // [R1]
          data_full_next = DATA_WR;
          cmd_op_next = i2cm_pkg::OP_WRITE;
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_ADDRW;
        end
      end
      C_HOLD: begin
        if (start_reg && data_full_reg) begin
          cmd_op_next = i2cm_pkg::OP_START; // [R6] [R7]
          cmd_tgl_next = ~cmd_tgl_reg;
          start_next = 1'b0;
          nak_done_next = 1'b0;
          c_state_next = C_STARTW;
        end else if (stop_reg) begin
          cmd_op_next = i2cm_pkg::OP_STOP; // [R13]
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_STOPW;
        end else if (rd_reg && !nak_done_reg && !rx_irq_reg) begin
          cmd_op_next = i2cm_pkg::OP_READ;
          cmd_nak_next = nak_reg; // [R9]
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_READW;
        end else if (!rd_reg && data_full_reg) begin
          shift_next = data_reg; // [R1]
          data_full_next = DATA_WR;
          cmd_op_next = i2cm_pkg::OP_WRITE;
          cmd_tgl_next = ~cmd_tgl_reg;
          c_state_next = C_DATAW;
        end
      end
      C_DATAW: begin
        if (done_evt) begin
          ack_next = l_ack_reg; // [R14]
          c_state_next = C_HOLD;
        end
      end
      C_READW: begin
        if (done_evt) begin
          rx_data_next = l_rx_reg;
          rx_irq_next = 1'b1; // [R10] [R11]
          ack_next = !cmd_nak_reg; // [R14]
          if (cmd_nak_reg) begin
            nak_next = 1'b0;
            nak_done_next = 1'b1; // [R13]
          end
          c_state_next = C_HOLD;
        end
      end
      C_STOPW: begin
        if (done_evt) begin
          stop_next = 1'b0;
          rd_next = 1'b0;
          nak_done_next = 1'b0;
          c_state_next = C_IDLE;
        end
      end
    endcase
    // events win over a clear in the same cycle
    if (first_evt && (c_state_reg == C_ADDRW || c_state_reg == C_DATAW) && !data_full_reg) begin
      tx_irq_next = 1'b1; // [R2]
    end
    if (done_evt && !start_reg && !stop_reg &&
        (((c_state_reg == C_ADDRW || c_state_reg == C_DATAW) && !l_ack_reg) ||
         (c_state_reg == C_READW && cmd_nak_reg))) begin
      nack_irq_next = 1'b1; // [R19]
    end
    if (START_SET) begin
      start_next = 1'b1;
    end
    if (STOP_SET) begin
      stop_next = 1'b1; // [R12]
    end
    if (NAK_SET) begin
      nak_next = 1'b1;
    end
    addr_st_next = (c_state_next == C_ADDRW); // [R17]
    data_st_next = (c_state_next == C_DATAW) || (c_state_next == C_READW); // [R18]
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      c_state_reg <= C_IDLE;
      data_reg <= i2cm_pkg::DATA_RST;
      shift_reg <= i2cm_pkg::DATA_RST;
      rx_data_reg <= i2cm_pkg::DATA_RST;
      {data_full_reg, start_reg, stop_reg, nak_reg, nak_done_reg} <= 5'h00;
      {tx_irq_reg, rx_irq_reg, ack_reg, ten_reg, rd_reg, nack_irq_reg} <= 6'h00;
      {addr_st_reg, data_st_reg, cmd_tgl_reg, cmd_nak_reg} <= 4'h0;
      cmd_op_reg <= i2cm_pkg::OP_NONE;
      addr_left_reg <= i2cm_pkg::ADDR_RST;
    end else begin
      c_state_reg <= c_state_next;
      data_reg <= data_next;
      shift_reg <= shift_next;
      rx_data_reg <= rx_data_next;
      {data_full_reg, start_reg, stop_reg, nak_reg, nak_done_reg} <=
        {data_full_next, start_next, stop_next, nak_next, nak_done_next};
      {tx_irq_reg, rx_irq_reg, ack_reg, ten_reg, rd_reg, nack_irq_reg} <=
        {tx_irq_next, rx_irq_next, ack_next, ten_next, rd_next, nack_irq_next};
      {addr_st_reg, data_st_reg, cmd_tgl_reg, cmd_nak_reg} <= {addr_st_next, data_st_next, cmd_tgl_next, cmd_nak_next};
      cmd_op_reg <= cmd_op_next;
      addr_left_reg <= addr_left_next;
    end
  end

  // ==========================================================
  // link bit engine: four link clocks per bit, SCL stretched by the slave
  always_comb begin
    l_state_next = l_state_reg;
    l_ph_next = l_ph_reg + 2'h1;
    l_bit_next = l_bit_reg;
    l_op_next = l_op_reg;
    l_sh_next = l_sh_reg;
    l_rx_next = l_rx_reg;
    l_nak_next = l_nak_reg;
    l_ack_next = l_ack_reg;
    done_tgl_next = done_tgl_reg;
    first_tgl_next = first_tgl_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    unique case (l_state_reg)
      L_IDLE: begin
        l_ph_next = i2cm_pkg::PH_FIRST;
        if (cmd_evt) begin
          l_op_next = cmd_op_reg;
          l_sh_next = shift_reg;
          l_nak_next = cmd_nak_reg;
          l_bit_next = i2cm_pkg::BIT_RST;
          l_state_next = (cmd_op_reg == i2cm_pkg::OP_START) ? L_START :
                         (cmd_op_reg == i2cm_pkg::OP_STOP) ? L_STOP : L_BIT;
        end
      end
      L_START: begin
        unique case (l_ph_reg)
          i2cm_pkg::PH_FIRST: sda_oe_next = 1'b0;
          i2cm_pkg::PH_RISE: scl_oe_next = 1'b0;
          i2cm_pkg::PH_SAMPLE: sda_oe_next = 1'b1;
          i2cm_pkg::PH_LAST: begin
            scl_oe_next = 1'b1;
            done_tgl_next = ~done_tgl_reg;
            l_state_next = L_IDLE;
          end
        endcase
      end
      L_BIT: begin
        unique case (l_ph_reg)
          i2cm_pkg::PH_FIRST: begin
            scl_oe_next = 1'b1; // [R21]
            if (l_bit_reg == i2cm_pkg::ACK_BIT_IDX) begin
              sda_oe_next = (l_op_reg == i2cm_pkg::OP_READ) && !l_nak_reg; // [R9] [R13]
            end else begin
              sda_oe_next = (l_op_reg == i2cm_pkg::OP_WRITE) && !l_sh_reg[7];
            end
          end
          i2cm_pkg::PH_RISE: scl_oe_next = 1'b0; // [R21]
          i2cm_pkg::PH_SAMPLE: begin
            if (!scl_s) begin
              l_ph_next = l_ph_reg; // slave holds SCL low: wait
            end else if (l_bit_reg == i2cm_pkg::ACK_BIT_IDX) begin
              l_ack_next = !sda_s; // [R4] [R21]
            end else begin
              l_sh_next = {l_sh_reg[6:0], sda_s}; // [R21]
              if (l_bit_reg == i2cm_pkg::BIT_RST) begin
                first_tgl_next = ~first_tgl_reg; // [R2]
              end
            end
          end
          i2cm_pkg::PH_LAST: begin
            scl_oe_next = 1'b1;
            if (l_bit_reg == i2cm_pkg::ACK_BIT_IDX) begin
              l_rx_next = l_sh_reg;
              done_tgl_next = ~done_tgl_reg;
              l_state_next = L_IDLE;
            end else begin
              l_bit_next = l_bit_reg + 4'h1;
            end
          end
        endcase
      end
      L_STOP: begin
        unique case (l_ph_reg)
          i2cm_pkg::PH_FIRST: begin
            scl_oe_next = 1'b1;
            sda_oe_next = 1'b1;
          end
          i2cm_pkg::PH_RISE: scl_oe_next = 1'b0;
          i2cm_pkg::PH_SAMPLE: sda_oe_next = 1'b0; // [R13]
          i2cm_pkg::PH_LAST: begin
            done_tgl_next = ~done_tgl_reg;
            l_state_next = L_IDLE;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge LINK_CLK) begin
    if (!l_rst_b) begin
      l_state_reg <= L_IDLE;
      l_ph_reg <= i2cm_pkg::PH_FIRST;
      l_bit_reg <= i2cm_pkg::BIT_RST;
      l_op_reg <= i2cm_pkg::OP_NONE;
      l_sh_reg <= i2cm_pkg::DATA_RST;
      l_rx_reg <= i2cm_pkg::DATA_RST;
      {l_nak_reg, l_ack_reg, done_tgl_reg, first_tgl_reg, scl_oe_reg, sda_oe_reg, pin_low_reg} <= 7'h00;
    end else begin
      l_state_reg <= l_state_next;
      l_ph_reg <= l_ph_next;
      l_bit_reg <= l_bit_next;
      l_op_reg <= l_op_next;
      l_sh_reg <= l_sh_next;
      l_rx_reg <= l_rx_next;
      {l_nak_reg, l_ack_reg, done_tgl_reg, first_tgl_reg, scl_oe_reg, sda_oe_reg, pin_low_reg} <=
        {l_nak_next, l_ack_next, done_tgl_next, first_tgl_next, scl_oe_next, sda_oe_next, 1'b0};
    end
  end

  // ==========================================================
  // outputs
  assign DATA_OUT = rx_data_reg;
  assign START_BIT = start_reg;
  assign STOP_BIT = stop_reg;
  assign NAK_BIT = nak_reg;
  assign TX_IRQ = tx_irq_reg;
  assign RX_IRQ = rx_irq_reg;
  assign ACK_FLAG = ack_reg;
  assign TEN_BIT_ADDR_FLAG = ten_reg;
  assign READ_DIR = rd_reg;
  assign ADDR_SHIFT_STATE = addr_st_reg;
  assign DATA_SHIFT_STATE = data_st_reg;
  assign NOT_ACK_IRQ_FLAG = nack_irq_reg;
  assign SCL_OUT = pin_low_reg;
  assign SCL_OE = scl_oe_reg;
  assign SDA_OUT = pin_low_reg;
  assign SDA_OE = sda_oe_reg;

  // ==========================================================
  // assertions
  sequence stop_cond_s;
    (scl_oe_reg && sda_oe_reg) ##1 (!scl_oe_reg && sda_oe_reg) ##1 (!scl_oe_reg && !sda_oe_reg);
  endsequence

  load_copy_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
    (c_state_reg == C_STARTW && done_evt) |=> (shift_reg == $past(data_reg) && c_state_reg == C_ADDRW))
    else $error("shift register not loaded from data register");
  txi_first_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
    (first_evt && (c_state_reg == C_ADDRW || c_state_reg == C_DATAW) && !data_full_reg) |=> TX_IRQ)
    else $error("transmit interrupt missing after first bit");
  restart_pri_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
    (c_state_reg == C_HOLD && start_reg && data_full_reg) |=> (cmd_op_reg == i2cm_pkg::OP_START &&
      c_state_reg == C_STARTW))
    else $error("repeated start not chosen over stop");
  rx_full_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    (c_state_reg == C_READW && done_evt) |=> (RX_IRQ && DATA_SHIFT_STATE == 1'b0))
    else $error("receive interrupt missing after byte");
  rx_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R11]
    (RX_IRQ && !DATA_RD) |=> RX_IRQ [*1] ##0 (!$past(DATA_RD)))
    else $error("receive flag dropped without data read");
  ten_flag_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R15]
    (c_state_reg == C_ADDRW && done_evt) |=> !TEN_BIT_ADDR_FLAG)
    else $error("ten-bit flag not cleared after address byte");
  nack_keep_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R20]
    (NOT_ACK_IRQ_FLAG && !START_SET && !STOP_SET) |=> NOT_ACK_IRQ_FLAG)
    else $error("not-ack flag cleared without start or stop");
  stop_seq_a: assert property (@(posedge LINK_CLK) disable iff (!l_rst_b) // [R13]
    (l_state_reg == L_STOP && l_ph_reg == i2cm_pkg::PH_FIRST) |=> stop_cond_s)
    else $error("stop condition malformed");
  nak_sent_a: assert property (@(posedge LINK_CLK) disable iff (!l_rst_b) // [R9]
    (l_state_reg == L_BIT && l_ph_reg == i2cm_pkg::PH_FIRST && l_bit_reg == i2cm_pkg::ACK_BIT_IDX &&
     l_op_reg == i2cm_pkg::OP_READ && l_nak_reg) |=> (!sda_oe_reg && scl_oe_reg) ##1 !scl_oe_reg)
    else $error("not acknowledge not released on SDA");
endmodule : i2cm_top

// ### test/i2cm_slave_model.sv
// i2c slave model answering a ten-bit-address read
`timescale 1ns/1ns
module i2cm_slave_model (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull,
  output logic scl_pull,
  // behaviour
  input wire logic ack_en,
  input wire logic slow,
  input wire logic [7:0] rd_byte
);
  // ==========================================
  // bit tracking
  logic [7:0] sh;
  logic [7:0] log_q [$];
  logic [3:0] cnt = 4'h0;
  logic rd_mode = 1'h0;
  logic sending = 1'h0;
  logic m_ack = 1'h0;
  // only the first byte after a start can be a read header
  logic hdr = 1'h0;
  int starts = 0;
  int stops = 0;
  initial sda_pull = 1'h0;
  initial scl_pull = 1'h0;
  always @(negedge sda) if (scl === 1'h1) begin
    cnt = 4'h0;
    sending = 1'h0;
    hdr = 1'h1;
    starts++;
  end
  always @(posedge sda) if (scl === 1'h1) stops++;
  always @(posedge scl) begin
    if (sending && cnt == 4'h8)
      m_ack = sda;
    sh = {sh[6:0], sda};
    cnt = cnt + 4'h1;
  end
  // slow mode stretches every low phase, so the master must wait for scl
  always @(negedge scl) if (slow) begin
    scl_pull = 1'h1;
    #400;
    scl_pull = 1'h0;
  end
  always @(negedge scl) begin
    if (cnt == 4'h8 && !sending) begin
      log_q.push_back(sh);
      rd_mode = hdr && (sh[7:3] == 5'h1E) && sh[0];
      hdr = 1'h0;
      sda_pull = ack_en;
    end else if (cnt == 4'h9) begin
      cnt = 4'h0;
      sending = rd_mode && !sending;
      rd_mode = 1'h0;
      sda_pull = sending && !rd_byte[7];
    end else
      sda_pull = sending && cnt < 4'h8 && !rd_byte[3'h7 - cnt[2:0]];
  end
endmodule : i2cm_slave_model

// ### test/i2cm_top_tb.sv
// self-checking bench for the ten-bit-address i2c master
`timescale 1ns/1ns
module i2cm_top_tb;
  // ==========================================
  // clocks, pins and bookkeeping
  logic clk, lclk, rst_b, wr, rd, st_set, sp_set, nk_set, ack_en, slow;
  logic [7:0] din, dout, rbyte;
  logic tx_irq, rx_irq, ack_f, ten_f, rd_dir, as_st, ds_st, nk_f, scl_oe, sda_oe, s_scl, s_sda;
  logic st_bit, sp_bit, nk_bit, scl_o, sda_o;
  logic rx_prev = 1'h0;
  logic dss_seen = 1'h0;
  wire scl = !(scl_oe || s_scl);
  wire sda = !(sda_oe || s_sda);
  logic [7:0] exp_q [$];
  int err_total = 0;
  int num_checks = 0;
  int stops0, s0, sz;
  i2cm_top u_i2cm_top (.CORE_CLK(clk), .RST_B(rst_b), .LINK_CLK(lclk), .DATA_IN(din), .DATA_WR(wr),
    .DATA_RD(rd), .DATA_OUT(dout), .START_SET(st_set), .STOP_SET(sp_set), .NAK_SET(nk_set),
    .START_BIT(st_bit), .STOP_BIT(sp_bit), .NAK_BIT(nk_bit), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq), .ACK_FLAG(ack_f),
    .TEN_BIT_ADDR_FLAG(ten_f), .READ_DIR(rd_dir), .ADDR_SHIFT_STATE(as_st), .DATA_SHIFT_STATE(ds_st),
    .NOT_ACK_IRQ_FLAG(nk_f), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE(sda_oe));
  i2cm_slave_model u_i2cm_slave_model (.scl(scl), .sda(sda), .sda_pull(s_sda), .scl_pull(s_scl),
    .ack_en(ack_en), .slow(slow), .rd_byte(rbyte));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // link clock has its own phase and a 125 ns period
  initial begin
    lclk = 1'h0;
    #17;
    forever begin
      #62 lclk = 1'h1;
      #63 lclk = 1'h0;
    end
  end
  // ==========================================
  // shared tasks
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask : pulse
  function automatic logic pick(input int k);
    case (k)
      0: return tx_irq;
      1: return rx_irq;
      2: return nk_f;
      default: return u_i2cm_slave_model.stops != stops0;
    endcase
  endfunction : pick
  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (pick(k) !== 1'h1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000)
      check("wait", 8'h00, 8'h01);
  endtask : wait_for
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // receive monitor takes the oldest expected byte on each new receive flag
  always @(negedge clk) begin
    if (rx_irq === 1'h1 && rx_prev !== 1'h1)
      check("rx data", dout, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    if (ds_st === 1'h1 && as_st === 1'h0)
      dss_seen <= 1'h1;
    rx_prev <= rx_irq;
  end
  // ==========================================
  // ten-bit read transaction
  task automatic txn(input logic [9:0] a, input logic [7:0] d);
    s0 = u_i2cm_slave_model.starts;
    rbyte = d;
    din = {5'h1E, a[9:8], 1'h0};
    pulse(wr);
    pulse(st_set);
    wait_for(0);
    check("ten flag", ten_f, 8'h01);
    check("read dir", rd_dir, 8'h00);
    check("addr state", as_st, 8'h01);
    din = a[7:0];
    pulse(wr);
    wait_for(0);
    check("ten flag", ten_f, 8'h00);
    check("ack flag", ack_f, 8'h01);
    pulse(st_set);
    check("start bit", st_bit, 8'h01);
    din = {5'h1E, a[9:8], 1'h1};
    pulse(wr);
    pulse(nk_set);
    check("nak bit", nk_bit, 8'h01);
    exp_q.push_back(d);
    wait_for(1);
    check("read dir", rd_dir, 8'h01);
    check("ack flag", ack_f, 8'h00);
    check("nak flag", nk_f, 8'h01);
    check("nak bit", nk_bit, 8'h00);
    check("start bit", st_bit, 8'h00);
    repeat (6) @(negedge clk);
    check("rx held", rx_irq, 8'h01);
    pulse(rd);
    check("rx clear", rx_irq, 8'h00);
    stops0 = u_i2cm_slave_model.stops;
    pulse(sp_set);
    check("stop bit", sp_bit, 8'h01);
    wait_for(3);
    repeat (10) @(negedge clk);
    check("stop bit", sp_bit, 8'h00);
    check("nak clear", nk_f, 8'h00);
    sz = u_i2cm_slave_model.log_q.size();
    check("hdr write", u_i2cm_slave_model.log_q[sz - 3], {5'h1E, a[9:8], 1'h0});
    check("low addr", u_i2cm_slave_model.log_q[sz - 2], a[7:0]);
    check("hdr read", u_i2cm_slave_model.log_q[sz - 1], {5'h1E, a[9:8], 1'h1});
    check("restart", 8'(u_i2cm_slave_model.starts - s0), 8'h02);
    check("nak sent", u_i2cm_slave_model.m_ack, 8'h01);
    check("data state", dss_seen, 8'h01);
  endtask : txn
  initial begin
    #(8000 * 50);
    err_total++;
    give_verdict();
  end
  initial begin
    void'($urandom(74));
    {din, wr, rd, st_set, sp_set, nk_set, rbyte} = '0;
    ack_en = 1'h1;
    slow = 1'h0;
    rst_b = 1'h0;
    repeat (12) @(negedge clk);
    rst_b = 1'h1;
    check("reset", {ten_f, rd_dir, as_st, ds_st, nk_f, ack_f, scl_oe, sda_oe}, 8'h00);
    check("reset bits", {st_bit, sp_bit, nk_bit, scl_o, sda_o}, 8'h00);
    repeat (10) @(negedge clk);
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      txn(10'($urandom), 8'($urandom));
    end
    // refused address: the flag must stick until stop is requested
    ack_en = 1'h0;
    din = {5'h1E, 2'($urandom), 1'h0};
    pulse(wr);
    pulse(st_set);
    wait_for(2);
    check("ack flag", ack_f, 8'h00);
    check("nak flag", nk_f, 8'h01);
    repeat (20) @(negedge clk);
    check("nak held", nk_f, 8'h01);
    stops0 = u_i2cm_slave_model.stops;
    pulse(sp_set);
    wait_for(3);
    check("nak clear", nk_f, 8'h00);
    give_verdict();
  end
endmodule : i2cm_top_tb
